// >>> rtl/pmd_pkg.sv
// Constants, register map and unit layout of the peripheral disable block.
// Notes on behaviour
// - While a unit's off bit is set, every clock edge to that unit is blocked so its logic stands still; the edge after the bit is written still passes.
// - An off bit of one means the unit is off with its clock cut; zero means on with its clock running.
// - While a unit is off, writes to its control and status registers are thrown away.
// - While a unit is off, reads of its control and status registers return data that must not be trusted.
// - Clearing a set off bit brings the unit's registers back loaded with their default values.
// - First register: bits 7 and 6 switch async ports two and one, bits 5 to 0 timers six down to one.
// - Second register: bits 7 and 6 switch sync ports two and one, bits 4 to 0 capture units five to one.
// - Bit 5 of the second register does not exist: it reads zero and writes to it are ignored.
// - All real off bits are read/write and clear to zero at reset, so every unit starts enabled.
`default_nettype none
package pmd_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int NUM_UNITS = 15;
    localparam int UNIT_ID_W = 4;
    localparam int CNT_W = 2;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_SERIAL_TIMERS = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_SYNC_CAPTURE = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_RUNNING_LO = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_RUNNING_HI = 4'h3;

    // ------------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] SERIAL_TIMERS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] SYNC_CAPTURE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] SYNC_CAPTURE_WMASK = 8'hdf;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
    localparam logic [DATA_W-1:0] OFF_UNIT_READ = 8'h00;

    // ------------------------------------------------------------------
    // Field positions in the second register
    // ------------------------------------------------------------------
    localparam int CAPTURE_LSB = 0;
    localparam int CAPTURE_MSB = 4;
    localparam int SYNC_LSB = 6;
    localparam int SYNC_MSB = 7;

    // ------------------------------------------------------------------
    // Unit index layout: 0-5 timers one-six, 6-7 async one-two,
    // 8-12 capture one-five, 13-14 sync one-two.
    // ------------------------------------------------------------------
    localparam int UNIT_TIMER_ONE = 0;
    localparam int UNIT_ASYNC_ONE = 6;
    localparam int UNIT_CAPTURE_ONE = 8;
    localparam int UNIT_SYNC_ONE = 13;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESTORE_TIME_NS = 80;
    localparam logic [CNT_W-1:0] RESTORE_CYCLES = CNT_W'(
        (RESTORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage
`default_nettype wire

// >>> rtl/clock_gate_cell.sv
// Latch-based clock gate for one peripheral unit.
`timescale 1ns/1ps
`default_nettype none
module clock_gate_cell (
    input wire logic clk,
    input wire logic enable,
    output logic gatedClk
);

    logic enLatch;

    // The latch is open only while clk is low, so the enable cannot
    // change during a high phase and chop a pulse.
    always_latch begin
        if (!clk) begin
            enLatch = enable;
        end
    end

    assign gatedClk = clk & enLatch;

endmodule // clock_gate_cell
`default_nettype wire

// >>> rtl/peripheral_module_disable.sv
// Per-unit clock and register-hold control with its register port.
`timescale 1ns/1ps
`default_nettype none
module peripheral_module_disable
    import pmd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regReadData,
    input wire logic [UNIT_ID_W-1:0] perTarget,
    input wire logic perWrite,
    input wire logic perRead,
    input wire logic [DATA_W-1:0] perWriteData,
    input wire logic [DATA_W-1:0] perReturnData,
    output logic [NUM_UNITS-1:0] perWriteEnable,
    output logic [DATA_W-1:0] perWriteDataOut,
    output logic [NUM_UNITS-1:0] perReadEnable,
    output logic perReadValid,
    output logic [DATA_W-1:0] perReadResult,
    output logic [NUM_UNITS-1:0] unitHold,
    output logic [NUM_UNITS-1:0] unitClk
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] serialTimers;
        logic [DATA_W-1:0] syncCapture;
        logic [NUM_UNITS-1:0] gateEn;
        logic [NUM_UNITS-1:0] hold;
        logic [NUM_UNITS-1:0][CNT_W-1:0] restoreCnt;
        logic [DATA_W-1:0] regReadData;
        logic [NUM_UNITS-1:0] perWriteEnable;
        logic [DATA_W-1:0] perWriteData;
        logic [NUM_UNITS-1:0] perReadEnable;
        logic rdStage1;
        logic rdBlocked1;
        logic rdStage2;
        logic rdBlocked2;
        logic perReadValid;
        logic [DATA_W-1:0] perReadResult;
    } state_t;

    state_t state_q;
    state_t state_d;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Gathers the off bits of both registers into the unit layout.
    function automatic logic [NUM_UNITS-1:0] offMask(
        input logic [DATA_W-1:0] serialTimers,
        input logic [DATA_W-1:0] syncCapture
    );
        logic [NUM_UNITS-1:0] mask;
        mask = '0;
        mask[UNIT_ASYNC_ONE+1:UNIT_TIMER_ONE] = serialTimers;
        mask[UNIT_CAPTURE_ONE+4:UNIT_CAPTURE_ONE] =
            syncCapture[CAPTURE_MSB:CAPTURE_LSB];
        mask[UNIT_SYNC_ONE+1:UNIT_SYNC_ONE] =
            syncCapture[SYNC_MSB:SYNC_LSB];
        return mask;
    endfunction

    // One-hot select of the unit that a peripheral access targets.
    function automatic logic [NUM_UNITS-1:0] unitSelect(
        input logic [UNIT_ID_W-1:0] id
    );
        logic [NUM_UNITS-1:0] sel;
        sel = '0;
        for (int i = 0; i < NUM_UNITS; i++) begin
            if (id == UNIT_ID_W'(i)) begin
                sel[i] = 1'b1;
            end
        end
        return sel;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic [NUM_UNITS-1:0] offNow;
    logic [NUM_UNITS-1:0] blockedNow;
    logic [NUM_UNITS-1:0] targetSel;
    logic [NUM_UNITS-1:0] runningNow;
    logic targetBlocked;

    always_comb begin
        state_d = state_q;

        offNow = offMask(state_q.serialTimers, state_q.syncCapture);
        // A unit is unusable while off or while its defaults are loaded.
        blockedNow = offNow | state_q.hold;
        runningNow = state_q.gateEn & ~state_q.hold;
        targetSel = unitSelect(perTarget);
        // Out-of-range targets select nothing and count as blocked.
        targetBlocked = ((targetSel & ~blockedNow) == '0);

        // Software writes to the off registers.
        if (regWrite) begin
            case (regAddr)
                ADDR_SERIAL_TIMERS: begin
                    state_d.serialTimers = regWriteData;
                end
                ADDR_SYNC_CAPTURE: begin
                    // Bit 5 has no storage; it stays zero.
                    state_d.syncCapture =
                        regWriteData & SYNC_CAPTURE_WMASK;
                end
                default: begin
                end
            endcase
        end

        // Register read data stand in the cycle after the strobe only.
        state_d.regReadData = '0;
        if (regRead) begin
            case (regAddr)
                ADDR_SERIAL_TIMERS: begin
                    state_d.regReadData = state_q.serialTimers;
                end
                ADDR_SYNC_CAPTURE: begin
                    state_d.regReadData =
                        state_q.syncCapture & SYNC_CAPTURE_WMASK;
                end
                ADDR_RUNNING_LO: begin
                    state_d.regReadData = runningNow[DATA_W-1:0];
                end
                ADDR_RUNNING_HI: begin
                    state_d.regReadData =
                        DATA_W'(runningNow[NUM_UNITS-1:DATA_W]);
                end
                default: begin
                    state_d.regReadData = UNMAPPED_READ;
                end
            endcase
        end

        // Clock gating and default restore, unit by unit.
        for (int i = 0; i < NUM_UNITS; i++) begin
            if (offNow[i]) begin
                // One means off: cut the clock and hold the registers.
                state_d.gateEn[i] = 1'b0;
                state_d.hold[i] = 1'b1;
                state_d.restoreCnt[i] = '0;
            end else if (!state_q.gateEn[i]) begin
                // Zero means on: clock back first, hold kept so the
                // unit sees clocked reset edges before it is released.
                state_d.gateEn[i] = 1'b1;
                state_d.restoreCnt[i] = RESTORE_CYCLES;
            end else if (state_q.restoreCnt[i] != '0) begin
                state_d.restoreCnt[i] =
                    state_q.restoreCnt[i] - CNT_W'(1);
                if (state_q.restoreCnt[i] == CNT_W'(1)) begin
                    state_d.hold[i] = 1'b0;
                end
            end
        end

        // Peripheral register writes pass only to usable units.
        state_d.perWriteEnable = '0;
        if (perWrite && !targetBlocked) begin
            state_d.perWriteEnable = targetSel;
        end
        if (perWrite) begin
            state_d.perWriteData = perWriteData;
        end

        // Peripheral register reads: enable, then return, then result.
        state_d.perReadEnable = '0;
        if (perRead && !targetBlocked) begin
            state_d.perReadEnable = targetSel;
        end
        state_d.rdStage1 = perRead;
        state_d.rdBlocked1 = targetBlocked;
        state_d.rdStage2 = state_q.rdStage1;
        state_d.rdBlocked2 = state_q.rdBlocked1;
        state_d.perReadValid = state_q.rdStage2;
        state_d.perReadResult = '0;
        if (state_q.rdStage2) begin
            // An off unit's return is not read; a fixed filler goes out.
            state_d.perReadResult = state_q.rdBlocked2 ?
                OFF_UNIT_READ : perReturnData;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q.serialTimers <= SERIAL_TIMERS_RESET;
            state_q.syncCapture <= SYNC_CAPTURE_RESET;
            state_q.gateEn <= '1;
            state_q.hold <= '0;
            state_q.restoreCnt <= '0;
            state_q.regReadData <= '0;
            state_q.perWriteEnable <= '0;
            state_q.perWriteData <= '0;
            state_q.perReadEnable <= '0;
            state_q.rdStage1 <= 1'b0;
            state_q.rdBlocked1 <= 1'b0;
            state_q.rdStage2 <= 1'b0;
            state_q.rdBlocked2 <= 1'b0;
            state_q.perReadValid <= 1'b0;
            state_q.perReadResult <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Clock gates
    // ------------------------------------------------------------------
    // The gated clocks are the only outputs not taken from a flop; their
    // enables are, and the latch in each cell keeps them glitch free.
    for (genvar g = 0; g < NUM_UNITS; g++) begin : gen_gate
        clock_gate_cell gate (
            .clk(clk),
            .enable(state_q.gateEn[g]),
            .gatedClk(unitClk[g])
        );
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign regReadData = state_q.regReadData;
    assign perWriteEnable = state_q.perWriteEnable;
    assign perWriteDataOut = state_q.perWriteData;
    assign perReadEnable = state_q.perReadEnable;
    assign perReadValid = state_q.perReadValid;
    assign perReadResult = state_q.perReadResult;
    assign unitHold = state_q.hold;

endmodule // peripheral_module_disable
`default_nettype wire

// >>> tb/peripheral_module_disable_properties.sv
// Concurrent checks on the ports of the peripheral disable block.
`timescale 1ns/1ps
`default_nettype none
module peripheral_module_disable_properties
    import pmd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regRead,
    input wire logic [DATA_W-1:0] regReadData,
    input wire logic [UNIT_ID_W-1:0] perTarget,
    input wire logic perWrite,
    input wire logic perRead,
    input wire logic [NUM_UNITS-1:0] perWriteEnable,
    input wire logic [NUM_UNITS-1:0] perReadEnable,
    input wire logic perReadValid,
    input wire logic [DATA_W-1:0] perReadResult,
    input wire logic [NUM_UNITS-1:0] unitHold,
    input wire logic [NUM_UNITS-1:0] unitClk
);
    // ----------------------------------------------------------------
    // Port relations
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Index fifteen selects no unit, so it must never count as held.
    logic heldTarget;
    assign heldTarget = (perTarget != 4'hf) && unitHold[perTarget];
    a_read_answer_lag: assert property (perRead |-> ##3 perReadValid)
        else $error("read answer not three cycles after request");
    a_valid_has_cause: assert property (perReadValid |->
        $past(perRead, 3)) else $error("read answer without a request");
    a_write_has_cause: assert property (|perWriteEnable |->
        $past(perWrite)) else $error("unit write strobe without a request");
    a_held_write_drop: assert property (perWrite && heldTarget |=>
        perWriteEnable == '0) else $error("write reached a held unit");
    a_held_read_empty: assert property (perRead && heldTarget |=>
        perReadEnable == '0 ##2 perReadResult == '0)
        else $error("read reached a held unit");
    a_single_strobe: assert property ($onehot0(perWriteEnable) &&
        $onehot0(perReadEnable)) else $error("more than one unit strobed");
    a_gate_low_phase: assert property (unitClk == '0)
        else $error("unit clock high while system clock low");
    a_stopped_is_held: assert property (@(negedge clk)
        disable iff (reset) (unitClk | unitHold) == '1)
        else $error("stopped unit not held");
    a_bit5_reads_zero: assert property (regRead &&
        regAddr == ADDR_SYNC_CAPTURE |=> regReadData[5] == 1'b0)
        else $error("missing bit of second register read as one");
    c_unit_off: cover property ($rose(|unitHold));
    c_unit_back: cover property ($fell(|unitHold));
    c_read_data: cover property (perReadValid && perReadResult != '0);
endmodule // peripheral_module_disable_properties
bind peripheral_module_disable peripheral_module_disable_properties props (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regRead(regRead),
    .regReadData(regReadData), .perTarget(perTarget), .perWrite(perWrite),
    .perRead(perRead), .perWriteEnable(perWriteEnable),
    .perReadEnable(perReadEnable), .perReadValid(perReadValid),
    .perReadResult(perReadResult), .unitHold(unitHold), .unitClk(unitClk)
);
`default_nettype wire

// >>> tb/peripheral_module_disable_test.sv
// Directed scenarios for the peripheral disable block.
`timescale 1ns/1ps
`default_nettype none
module peripheral_module_disable_test
    import pmd_pkg::*;
;
    localparam logic [NUM_UNITS-1:0] ALL_ON = '1;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWriteData = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [UNIT_ID_W-1:0] perTarget = '0;
    logic perWrite = 1'b0;
    logic perRead = 1'b0;
    logic [DATA_W-1:0] perWriteData = '0;
    logic [DATA_W-1:0] perReturnData = '0;
    logic [DATA_W-1:0] regReadData, perWriteDataOut, perReadResult;
    logic [NUM_UNITS-1:0] perWriteEnable, perReadEnable, unitHold, unitClk;
    logic perReadValid;
    int errTotal = 0;
    int totalChecks = 0;
    int cycles = 0;
    peripheral_module_disable dut (.clk(clk), .reset(reset),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
        .regRead(regRead), .regReadData(regReadData), .perTarget(perTarget),
        .perWrite(perWrite), .perRead(perRead), .perWriteData(perWriteData),
        .perReturnData(perReturnData), .perWriteEnable(perWriteEnable),
        .perWriteDataOut(perWriteDataOut), .perReadEnable(perReadEnable),
        .perReadValid(perReadValid), .perReadResult(perReadResult),
        .unitHold(unitHold), .unitClk(unitClk));
    always #20 clk = ~clk;
    // ----------------------------------------------------------------
    // Bus cycles and comparison
    // ----------------------------------------------------------------
    task automatic giveVerdict();
        if (errTotal == 0 && totalChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // A hung handshake would stall the run, so the cycle count is capped.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errTotal++;
            giveVerdict();
        end
    end
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] want);
        totalChecks++;
        if (seen !== want) begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] want);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 check("regReadData", regReadData, want);
    endtask
    task automatic pw(input int t, input logic [7:0] d,
                      input logic [NUM_UNITS-1:0] en);
        @(posedge clk);
        perTarget <= UNIT_ID_W'(t);
        perWriteData <= d;
        perWrite <= 1'b1;
        @(posedge clk);
        perWrite <= 1'b0;
        #1 check("perWriteEnable", perWriteEnable, en);
        check("perWriteDataOut", perWriteDataOut, d);
    endtask
    // The return bus is inverted once sampled so stale data cannot match.
    task automatic pr(input int t, input logic [7:0] ret,
                      input logic [NUM_UNITS-1:0] en);
        @(posedge clk);
        perTarget <= UNIT_ID_W'(t);
        perRead <= 1'b1;
        @(posedge clk);
        perRead <= 1'b0;
        #1 check("perReadEnable", perReadEnable, en);
        @(posedge clk);
        perReturnData <= ret;
        @(posedge clk);
        perReturnData <= ~ret;
        #1 check("perReadValid", perReadValid, 1'b1);
        check("perReadResult", perReadResult,
              en != '0 ? ret : 8'h00);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic testResetState();
        rd(ADDR_SERIAL_TIMERS, 8'h00);
        rd(ADDR_SYNC_CAPTURE, 8'h00);
        check("unitHold", unitHold, '0);
        check("unitClk", unitClk, ALL_ON);
    endtask
    task automatic testRegisterBus();
        wr(ADDR_SERIAL_TIMERS, 8'hff);
        wr(ADDR_SYNC_CAPTURE, 8'hff);
        rd(ADDR_SERIAL_TIMERS, 8'hff);
        rd(ADDR_SYNC_CAPTURE, 8'hdf);
        wr(4'hf, 8'ha5);
        rd(4'hf, 8'h00);
        wr(ADDR_SERIAL_TIMERS, 8'h00);
        wr(ADDR_SYNC_CAPTURE, 8'h00);
        rd(ADDR_SYNC_CAPTURE, 8'h00);
        repeat (4) @(posedge clk);
    endtask
    task automatic testEachUnit();
        logic [ADDR_W-1:0] a;
        logic [NUM_UNITS-1:0] one;
        int b;
        for (int u = 0; u < NUM_UNITS; u++) begin
            a = u < UNIT_CAPTURE_ONE ? ADDR_SERIAL_TIMERS : ADDR_SYNC_CAPTURE;
            b = u < UNIT_CAPTURE_ONE ? u : u < UNIT_SYNC_ONE ?
                u - UNIT_CAPTURE_ONE : u - UNIT_SYNC_ONE + 6;
            one = NUM_UNITS'(1) << u;
            wr(a, 8'(1 << b));
            repeat (2) @(posedge clk);
            #1 check("unitHold", unitHold, one);
            check("unitClk", unitClk, ALL_ON ^ one);
            rd(a, 8'(1 << b));
            rd(ADDR_RUNNING_LO, 8'(ALL_ON ^ one));
            rd(ADDR_RUNNING_HI, 8'((ALL_ON ^ one) >> 8));
            pw(u, 8'(u + 8'h30), '0);
            pr(u, 8'(u + 8'h90), '0);
            wr(a, 8'h00);
            pw(u, 8'h5a, '0);
            check("unitHold", unitHold, one);
            check("unitClk", unitClk, ALL_ON);
            @(posedge clk);
            #1 check("unitHold", unitHold, '0);
            pw(u, 8'(u + 8'h10), one);
            pr(u, 8'(u + 8'hb0), one);
        end
    endtask
    // Reset in mid-run must clear off bits that software left set.
    task automatic testMidReset();
        wr(ADDR_SERIAL_TIMERS, 8'h3c);
        wr(ADDR_SYNC_CAPTURE, 8'h41);
        repeat (2) @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        #1 check("unitHold", unitHold, '0);
        @(posedge clk);
        reset <= 1'b0;
        rd(ADDR_SERIAL_TIMERS, 8'h00);
        rd(ADDR_SYNC_CAPTURE, 8'h00);
        rd(ADDR_RUNNING_HI, 8'h7f);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        testResetState();
        testRegisterBus();
        testEachUnit();
        testMidReset();
        pw(15, 8'h77, '0);
        pr(15, 8'h66, '0);
        giveVerdict();
    end
endmodule // peripheral_module_disable_test
`default_nettype wire
